// ===== core/fup_pkg.sv
package fup_pkg;
    localparam logic [7:0] A_CTRL   = 8'h00;
    localparam logic [7:0] A_HDR    = 8'h04;
    localparam logic [7:0] A_HDR2   = 8'h08;
    localparam logic [7:0] A_LBA    = 8'h0C;
    localparam logic [7:0] A_EXPTAG = 8'h10;
    localparam logic [7:0] A_BLKLEN = 8'h14;
    localparam logic [7:0] A_GO     = 8'h18;
    localparam logic [7:0] A_CMD    = 8'h1C;
    localparam logic [7:0] A_STAT   = 8'h20;
    localparam logic [7:0] A_UA     = 8'h24;
    localparam logic [7:0] A_REFTAG = 8'h28;
    localparam logic [7:0] A_DLEN   = 8'h2C;
    localparam logic [7:0] A_FMTLEN = 8'h30;
    // scsi status codes
    localparam logic [7:0] SC_GOOD  = 8'h00;
    localparam logic [7:0] SC_CHECK = 8'h02;
    localparam logic [7:0] SC_BUSY  = 8'h08;
    localparam logic [7:0] SC_QFULL = 8'h28;
    // sense keys and additional codes
    localparam logic [3:0] SK_NONE  = 4'h0;
    localparam logic [3:0] SK_NREDY = 4'h2;
    localparam logic [3:0] SK_MEDIUM = 4'h3;
    localparam logic [3:0] SK_ILLEG = 4'h5;
    localparam logic [15:0] AQ_NONE     = 16'h0000;
    localparam logic [15:0] AQ_FMT_PROG = 16'h0404;
    localparam logic [15:0] AQ_BAD_CDB  = 16'h2400;
    localparam logic [15:0] AQ_BAD_PARM = 16'h2600;
    localparam logic [15:0] AQ_DL_MISS  = 16'h1901;
    localparam logic [15:0] AQ_DL_ERR   = 16'h1900;
    localparam logic [15:0] AQ_FMT_BAD  = 16'h3100;
    // command kinds written to A_CMD
    localparam logic [1:0] CK_OTHER = 2'h0;
    localparam logic [1:0] CK_RSENSE = 2'h1;
    localparam logic [1:0] CK_INQ   = 2'h2;
    // protection info code values (00b,01b,10b,11b)
    localparam logic [1:0] PIC_00 = 2'h0;
    localparam logic [1:0] PIC_01 = 2'h1;
    localparam logic [1:0] PIC_10 = 2'h2;
    localparam logic [1:0] PIC_11 = 2'h3;
    // protection bytes behind user data at n
    localparam logic [15:0] PI_BYTES    = 16'h0008;
    localparam int          PI_GUARD_OF = 0;
    localparam int          PI_APP_OF   = 2;
    localparam int          PI_REF_OF   = 4;
    localparam logic [7:0]  PI_FILL     = 8'hFF;
    localparam logic [3:0]  PAT_OF_SHORT = 4'h4;
    localparam logic [3:0]  PAT_OF_LONG  = 4'h8;
    localparam logic [15:0] BLKLEN_RST  = 16'h0200;

    typedef enum logic [1:0] {
        FUP_IDLE   = 2'b00,
        FUP_QUEUED = 2'b01,
        FUP_ACTIVE = 2'b11
    } fup_state_e;

    typedef struct packed {
        logic       psel;
        logic       penable;
        logic       pwrite;
        logic [7:0] paddr;
        logic [31:0] pwdata;
    } fup_apb_s;

    typedef struct packed {
        logic start;
        logic done_ok;
        logic abort;
        logic dlist_missing;
        logic dlist_err;
        logic plist_missing;
        logic blk_step;
    } fup_ev_s;

    typedef struct packed {
        logic       primary_list_disable;
        logic       cert;
        logic       stop_on_list_error;
        logic       ip;
        logic       dsp;
        logic       immed;
        logic [1:0] ptype;
    } fup_opt_s;
endpackage

// ===== core/fup_core.sv
`timescale 1ns/1ps
// Function
// - active format: other commands get check
// - queued format: queue full or busy
// - request sense during format: not ready
// - inquiry during format answers good
// - interrupted format leaves degraded mode
// - accepted format raises attention for others
// - short header field layout decoded
// - long header field layout decoded
// - protection code selects type 0/1/2
// - bad protection combinations rejected illegal request
// - type 0 disables protection info
// - type 1/2 add eight 0xFF bytes
// - guard, application, reference tag order
// - type 1 reference tag seeded by lba
// - type 2 tag seeded by expected tag
// - options invalid: defaults, nonzero bits rejected
// - primary list use and its constraint
// - certify disable steers certification
// - bare command certification from mode bit
// - stop bit required; list errors reported
// - pattern bit: parse or zero fill
// - immediate status and deferred errors
// - save disable steers parameter saving
module fup_core
    import fup_pkg::*;
(
    input  wire logic        sys_clk,
    input  wire logic        nrst,
    input  wire fup_apb_s    apb,
    input  wire fup_ev_s     ev,
    output logic [31:0]      prdata,
    output logic             pready,
    output logic             pslverr,
    output logic             fmt_active,
    output logic             rw_blocked
);
    typedef struct packed {
        fup_state_e  st;
        logic        degraded;
        logic        protection_enabled_flag;
        logic [1:0]  ptype;
        logic        deferred;
        logic [3:0]  dkey;
        logic [15:0] daq;
        logic [7:0]  ua;
        logic [31:0] reftag;
        logic [10:0] ctrl;
        logic [31:0] hdr;
        logic [31:0] hdr2;
        logic [31:0] lba;
        logic [31:0] exptag;
        logic [15:0] blklen;
        logic [16:0] fmtlen;
        logic        rvalid;
        logic [7:0]  rstat;
        logic [3:0]  rkey;
        logic [15:0] raq;
        fup_opt_s    opt;
        logic [31:0] prdata;
        logic        pready;
        logic        pslverr;
        logic        fmt_active;
        logic        rw_blocked;
    } fup_reg_s;

    fup_reg_s q_reg, q_next;

    logic       acc;
    logic       wr;
    logic       go_w;
    logic       cmd_w;
    logic       present;
    logic       longh;
    logic       options_valid_bit;
    logic [7:0] b1;
    logic [2:0] usage;
    logic [1:0] pic;
    logic       cdb_bad;
    logic       combo_bad;
    logic       pl_bad;
    logic       addr_ok;
    logic       fail;
    fup_opt_s   opt_w;
    logic [7:0] issuer_oh;

    assign acc   = apb.psel & apb.penable & q_reg.pready;
    assign wr    = acc & apb.pwrite;
    assign go_w  = wr & (apb.paddr == A_GO);
    assign cmd_w = wr & (apb.paddr == A_CMD);

    always_comb begin
        present = q_reg.ctrl[2];
        longh   = q_reg.ctrl[3];
        pic     = q_reg.ctrl[5:4];
        b1      = q_reg.hdr[15:8];
        usage   = present ? q_reg.hdr[2:0] : 3'h0;
        options_valid_bit     = present & b1[7];
        issuer_oh = 8'h01 << q_reg.ctrl[10:8];
        cdb_bad = (pic == PIC_01);
        combo_bad = 1'b0;
        opt_w.ptype = 2'h0;
        case ({pic, usage})
            {PIC_00, 3'h0}: opt_w.ptype = 2'h0;
            {PIC_10, 3'h0}: opt_w.ptype = 2'h1;
            {PIC_11, 3'h0}: opt_w.ptype = 2'h2;
            default:        combo_bad = 1'b1;
        endcase
        // default options when the list or its valid bit is absent
        opt_w.primary_list_disable  = options_valid_bit ? b1[6] : 1'b0;
        opt_w.stop_on_list_error  = options_valid_bit ? b1[4] : 1'b1;
        opt_w.ip    = options_valid_bit ? b1[3] : 1'b0;
        opt_w.dsp   = options_valid_bit ? q_reg.ctrl[6] : 1'b1;
        opt_w.immed = present & b1[1];
        if (present) begin
            opt_w.cert = options_valid_bit ? ~b1[5] : 1'b0;
        end else begin
            opt_w.cert = q_reg.ctrl[1];
        end
        pl_bad = present & (combo_bad
               | (~options_valid_bit & ((|b1[6:3]) | q_reg.ctrl[6]))
               | (options_valid_bit & ~b1[4])
               | (options_valid_bit & ~b1[5] & b1[6])
               | (longh & (|q_reg.hdr[31:24])));
    end

    always_comb begin
        case (apb.paddr)
            A_CTRL, A_HDR, A_HDR2, A_LBA, A_EXPTAG, A_BLKLEN,
            A_GO, A_CMD, A_STAT, A_UA, A_REFTAG, A_DLEN,
            A_FMTLEN: addr_ok = 1'b1;
            default:  addr_ok = 1'b0;
        endcase
    end

    // list faults only end the format while it is running
    assign fail = ev.abort | ev.dlist_missing | ev.dlist_err
                | (ev.plist_missing & ~q_reg.opt.primary_list_disable);

    always_comb begin
        q_next = q_reg;
        q_next.pready  = apb.psel & ~apb.penable;
        q_next.pslverr = apb.psel & ~apb.penable & ~addr_ok;
        q_next.prdata  = 32'h0000_0000;
        if (apb.psel & ~apb.penable & ~apb.pwrite) begin
            case (apb.paddr)
                A_CTRL:   q_next.prdata = {21'h0, q_reg.ctrl};
                A_HDR:    q_next.prdata = q_reg.hdr;
                A_HDR2:   q_next.prdata = q_reg.hdr2;
                A_LBA:    q_next.prdata = q_reg.lba;
                A_EXPTAG: q_next.prdata = q_reg.exptag;
                A_BLKLEN: q_next.prdata = {16'h0, q_reg.blklen};
                A_CMD:    q_next.prdata = {q_reg.raq, q_reg.rvalid,
                                           q_reg.deferred, 2'h0,
                                           q_reg.rkey, q_reg.rstat};
                A_STAT:   q_next.prdata = {14'h0,
                              (longh ? PAT_OF_LONG : PAT_OF_SHORT),
                              q_reg.opt, q_reg.protection_enabled_flag, q_reg.degraded,
                              q_reg.ptype, q_reg.st};
                A_UA:     q_next.prdata = {24'h0, q_reg.ua};
                A_REFTAG: q_next.prdata = q_reg.reftag;
                A_DLEN:   q_next.prdata = longh ? q_reg.hdr2
                              : {16'h0, q_reg.hdr[23:16],
                                 q_reg.hdr[31:24]};
                A_FMTLEN: q_next.prdata = {15'h0, q_reg.fmtlen};
                default:  q_next.prdata = 32'h0000_0000;
            endcase
        end
        if (wr) begin
            case (apb.paddr)
                A_CTRL:   q_next.ctrl   = apb.pwdata[10:0];
                A_HDR:    q_next.hdr    = apb.pwdata;
                A_HDR2:   q_next.hdr2   = apb.pwdata;
                A_LBA:    q_next.lba    = apb.pwdata;
                A_EXPTAG: q_next.exptag = apb.pwdata;
                A_BLKLEN: q_next.blklen = apb.pwdata[15:0];
                A_UA:     q_next.ua     = q_reg.ua & ~apb.pwdata[7:0];
                default:  q_next.ua     = q_reg.ua;
            endcase
        end
        if (go_w) begin
            q_next.rvalid = 1'b1;
            if (q_reg.st == FUP_ACTIVE) begin
                q_next.rstat = SC_CHECK;
                q_next.rkey  = SK_NREDY;
                q_next.raq   = AQ_FMT_PROG;
            end else if (q_reg.st == FUP_QUEUED) begin
                q_next.rstat = q_reg.ctrl[0] ? SC_BUSY
                                             : SC_QFULL;
                q_next.rkey  = SK_NONE;
                q_next.raq   = AQ_NONE;
            end else if (cdb_bad) begin
                q_next.rstat = SC_CHECK;
                q_next.rkey  = SK_ILLEG;
                q_next.raq   = AQ_BAD_CDB;
            end else if (pl_bad) begin
                q_next.rstat = SC_CHECK;
                q_next.rkey  = SK_ILLEG;
                q_next.raq   = AQ_BAD_PARM;
            end else begin
                q_next.st     = FUP_QUEUED;
                q_next.opt    = opt_w;
                q_next.ua     = q_next.ua | ~issuer_oh;
                q_next.rvalid = opt_w.immed;
                q_next.rstat  = SC_GOOD;
                q_next.rkey   = SK_NONE;
                q_next.raq    = AQ_NONE;
                q_next.deferred = 1'b0;
            end
        end
        if (cmd_w) begin
            q_next.rvalid = 1'b1;
            q_next.rstat  = SC_GOOD;
            q_next.rkey   = SK_NONE;
            q_next.raq    = AQ_NONE;
            case (q_reg.st)
                FUP_ACTIVE: begin
                    if (apb.pwdata[1:0] == CK_OTHER) begin
                        q_next.rstat = SC_CHECK;
                    end
                    if (apb.pwdata[1:0] != CK_INQ) begin
                        q_next.rkey = SK_NREDY;
                        q_next.raq  = AQ_FMT_PROG;
                    end
                end
                FUP_QUEUED: begin
                    if (apb.pwdata[1:0] == CK_OTHER) begin
                        q_next.rstat = q_reg.ctrl[0] ? SC_BUSY
                                                     : SC_QFULL;
                    end
                end
                default: begin
                    if (apb.pwdata[1:0] == CK_RSENSE) begin
                        q_next.rkey = q_reg.dkey;
                        q_next.raq  = q_reg.daq;
                        q_next.deferred = 1'b0;
                    end else if (apb.pwdata[1:0] == CK_OTHER
                                 && q_reg.degraded) begin
                        q_next.rstat = SC_CHECK;
                        q_next.rkey  = SK_MEDIUM;
                        q_next.raq   = AQ_FMT_BAD;
                    end
                end
            endcase
        end
        case (q_reg.st)
            FUP_QUEUED: begin
                if (ev.start) begin
                    q_next.st = FUP_ACTIVE;
                    case (q_reg.opt.ptype)
                        2'h1:    q_next.reftag = q_reg.lba;
                        2'h2:    q_next.reftag = q_reg.exptag;
                        default: q_next.reftag = 32'h0000_0000;
                    endcase
                end
            end
            FUP_ACTIVE: begin
                if (ev.blk_step && q_reg.opt.ptype != 2'h0) begin
                    q_next.reftag = q_reg.reftag + 32'h0000_0001;
                end
                if (fail) begin
                    q_next.st = FUP_IDLE;
                    q_next.degraded = 1'b1;
                    q_next.dkey = SK_MEDIUM;
                    q_next.daq  = ev.dlist_err ? AQ_DL_ERR
                                : ev.abort ? AQ_FMT_BAD : AQ_DL_MISS;
                    if (q_reg.opt.immed) begin
                        q_next.deferred = 1'b1;
                    end else begin
                        q_next.rvalid = 1'b1;
                        q_next.rstat  = SC_CHECK;
                        q_next.rkey   = SK_MEDIUM;
                        q_next.raq    = ev.dlist_err ? AQ_DL_ERR
                                : ev.abort ? AQ_FMT_BAD : AQ_DL_MISS;
                    end
                end else if (ev.done_ok) begin
                    q_next.st = FUP_IDLE;
                    q_next.degraded = 1'b0;
                    q_next.ptype    = q_reg.opt.ptype;
                    q_next.protection_enabled_flag  = |q_reg.opt.ptype;
                    q_next.fmtlen   = {1'b0, q_reg.blklen}
                        + ((|q_reg.opt.ptype) ? {1'b0, PI_BYTES}
                                              : 17'h0_0000);
                    if (!q_reg.opt.immed) begin
                        q_next.rvalid = 1'b1;
                        q_next.rstat  = SC_GOOD;
                        q_next.rkey   = SK_NONE;
                        q_next.raq    = AQ_NONE;
                    end
                end
            end
            default: q_next.st = q_next.st;
        endcase
        q_next.fmt_active = (q_next.st == FUP_ACTIVE);
        q_next.rw_blocked = q_next.degraded | q_next.fmt_active;
    end

    always_ff @(posedge sys_clk) begin
        if (!nrst) begin
            q_reg        <= '0;
            q_reg.st     <= FUP_IDLE;
            q_reg.blklen <= BLKLEN_RST;
            q_reg.fmtlen <= {1'b0, BLKLEN_RST};
            q_reg.dkey   <= SK_NONE;
            q_reg.daq    <= AQ_NONE;
        end else begin
            q_reg <= q_next;
        end
    end

    assign prdata     = q_reg.prdata;
    assign pready     = q_reg.pready;
    assign pslverr    = q_reg.pslverr;
    assign fmt_active = q_reg.fmt_active;
    assign rw_blocked = q_reg.rw_blocked;

    default clocking @(posedge sys_clk); endclocking
    default disable iff (!nrst);

    active_check_a: assert property (
        cmd_w && q_reg.st == FUP_ACTIVE && apb.pwdata[1:0] == CK_OTHER
        |=> q_reg.rstat == SC_CHECK && q_reg.rvalid)
        else $error("active format did not answer check");
    queued_answer_a: assert property (
        cmd_w && q_reg.st == FUP_QUEUED && apb.pwdata[1:0] == CK_OTHER
        |=> q_reg.rstat == ($past(q_reg.ctrl[0]) ? SC_BUSY : SC_QFULL))
        else $error("queued format gave wrong status");
    sense_progress_a: assert property (
        cmd_w && q_reg.st == FUP_ACTIVE && apb.pwdata[1:0] == CK_RSENSE
        |=> q_reg.rstat == SC_GOOD && q_reg.rkey == SK_NREDY
            && q_reg.raq == AQ_FMT_PROG)
        else $error("request sense wrong during format");
    inquiry_good_a: assert property (
        cmd_w && q_reg.st != FUP_IDLE && apb.pwdata[1:0] == CK_INQ
        |=> q_reg.rstat == SC_GOOD)
        else $error("inquiry not good during format");
    degraded_entry_a: assert property (
        q_reg.st == FUP_ACTIVE && fail
        |=> q_reg.degraded ##1 q_reg.rw_blocked)
        else $error("interrupted format not degraded");
    unit_attn_a: assert property (
        go_w && q_reg.st == FUP_IDLE && !cdb_bad && !pl_bad
        |=> &(q_reg.ua | $past(issuer_oh)))
        else $error("unit attention missing for others");
    reject_hold_a: assert property (
        go_w && q_reg.st == FUP_IDLE && (cdb_bad || pl_bad)
        |=> q_reg.st == FUP_IDLE && q_reg.rkey == SK_ILLEG
            && !q_reg.fmt_active)
        else $error("rejected format left idle state");
    reftag_step_a: assert property (
        q_reg.st == FUP_ACTIVE && ev.blk_step && q_reg.opt.ptype != 2'h0
        && !fail && !ev.done_ok
        |=> q_reg.reftag == $past(q_reg.reftag) + 32'h0000_0001)
        else $error("reference tag did not step");
    prot_commit_a: assert property (
        q_reg.st == FUP_ACTIVE && ev.done_ok && !fail
        |=> q_reg.ptype == $past(q_reg.opt.ptype)
            && q_reg.protection_enabled_flag == (q_reg.ptype != 2'h0)
            && q_reg.fmtlen == {1'b0, q_reg.blklen}
               + (q_reg.protection_enabled_flag ? {1'b0, PI_BYTES} : 17'h0_0000))
        else $error("protection result wrong after format");
    busy_go_a: assert property (
        go_w && q_reg.st != FUP_IDLE && !ev.done_ok
        |=> q_reg.rstat == (($past(q_reg.st) == FUP_ACTIVE) ? SC_CHECK
            : $past(q_reg.ctrl[0]) ? SC_BUSY : SC_QFULL))
        else $error("format while busy got wrong status");
    deferred_set_a: assert property (
        q_reg.st == FUP_ACTIVE && fail && q_reg.opt.immed
        |=> q_reg.deferred && q_reg.dkey == SK_MEDIUM)
        else $error("deferred error not latched");
    cdb_reject_a: assert property (
        go_w && q_reg.st == FUP_IDLE && q_reg.ctrl[5:4] == PIC_01
        |=> q_reg.rstat == SC_CHECK && q_reg.rkey == SK_ILLEG
            && q_reg.raq == AQ_BAD_CDB)
        else $error("protection code not rejected");
    type_zero_a: assert property (
        q_reg.st == FUP_ACTIVE && ev.done_ok && !fail
        && q_reg.opt.ptype == 2'h0
        |=> !q_reg.protection_enabled_flag && q_reg.fmtlen == {1'b0, q_reg.blklen})
        else $error("type 0 format left protection on");
    stop_bit_a: assert property (
        go_w && q_reg.st == FUP_IDLE && q_reg.ctrl[2]
        && q_reg.ctrl[5:4] != PIC_01 && q_reg.hdr[15] && !q_reg.hdr[12]
        |=> q_reg.rkey == SK_ILLEG && q_reg.raq == AQ_BAD_PARM)
        else $error("cleared stop bit not rejected");
endmodule

// ===== sim/fup_far.sv
`timescale 1ns/1ps
// drive side model: start, block progress and outcome events
module fup_far
    import fup_pkg::*;
(
    input  wire logic sys_clk,
    output fup_ev_s   ev
);
    initial ev = '0;

    // one-cycle pulse with a quiet cycle after it
    task automatic pulse(input fup_ev_s e);
        @(posedge sys_clk);
        ev <= e;
        @(posedge sys_clk);
        ev <= '0;
    endtask

    // the app tag field is never touched here
    task automatic begin_fmt(input int nblk);
        fup_ev_s e;
        e = '0;
        e.start = 1'b1;
        pulse(e);
        e = '0;
        e.blk_step = 1'b1;
        repeat (nblk) pulse(e);
    endtask

    // outcome: good end, interruption or defect list trouble
    task automatic end_fmt(input fup_ev_s e);
        pulse(e);
    endtask
endmodule

// ===== sim/tb_top.sv
`timescale 1ns/1ps
`define CHK(a, b) begin cmp_count++; if ((a) !== (b)) begin \
    bad_count++; \
    $display("[ERR] %0t got %0h exp %0h", $time, (a), (b)); end end
module tb_top
    import fup_pkg::*;
;
    logic        sys_clk;
    logic        nrst;
    fup_apb_s    apb;
    fup_ev_s     ev;
    fup_ev_s     oc;
    logic [31:0] prdata;
    logic        pready;
    logic        pslverr;
    logic        fmt_active;
    logic        rw_blocked;
    logic [31:0] q;
    logic        err;
    int          bad_count;
    int          cmp_count;
    int          i;
    logic [31:0] rc [6] = '{32'h14, 32'h34, 32'h04, 32'h04, 32'h04, 32'h04};
    logic [31:0] rh [6] = '{32'hB000, 32'hB001, 32'hB001, 32'h4000,
                            32'hA000, 32'hD000};
    logic [15:0] ra [6] = '{AQ_BAD_CDB, AQ_BAD_PARM, AQ_BAD_PARM,
                            AQ_BAD_PARM, AQ_BAD_PARM, AQ_BAD_PARM};

    fup_core i_dut (
        .sys_clk    (sys_clk),
        .nrst       (nrst),
        .apb        (apb),
        .ev         (ev),
        .prdata     (prdata),
        .pready     (pready),
        .pslverr    (pslverr),
        .fmt_active (fmt_active),
        .rw_blocked (rw_blocked)
    );

    fup_far i_far (
        .sys_clk (sys_clk),
        .ev      (ev)
    );

    initial begin
        sys_clk = 1'b0;
        forever #12.5 sys_clk = ~sys_clk;
    end

    task automatic close_out();
        if (bad_count == 0 && cmp_count > 0) begin
            $display("All checks passed");
        end else begin
            $display("Checks failed");
        end
        $finish;
    endtask

    // request held until pready is seen high at a rising edge
    task automatic xfer(input logic w, input logic [7:0] a,
                        input logic [31:0] d);
        int n;
        @(posedge sys_clk);
        apb <= '{1'b1, 1'b0, w, a, d};
        @(posedge sys_clk);
        apb.penable <= 1'b1;
        for (n = 0; n < 16; n++) begin
            @(posedge sys_clk);
            if (pready === 1'b1) break;
        end
        q = prdata;
        err = pslverr;
        apb <= '0;
        if (n == 16) begin
            bad_count++;
            close_out();
        end
    endtask

    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        xfer(1'b1, a, d);
    endtask

    task automatic rd(input logic [7:0] a);
        xfer(1'b0, a, 32'h0);
    endtask

    task automatic cmd(input logic [1:0] k);
        wr(A_CMD, {30'h0, k});
        rd(A_CMD);
    endtask

    function automatic logic [31:0] resp(input logic [15:0] asc,
                                         input logic [3:0] key,
                                         input logic [7:0] st);
        return {asc, 4'h8, key, st};
    endfunction

    initial begin
        nrst = 1'b0;
        apb = '0;
        bad_count = 0;
        cmp_count = 0;
        repeat (10) @(posedge sys_clk);
        nrst <= 1'b1;
        rd(A_STAT);
        `CHK(q, 32'h0001_0000)
        rd(A_FMTLEN);
        `CHK(q, 32'h200)
        rd(8'h40);
        `CHK({err, q}, 33'h1_0000_0000)
        // every rejection must leave the unit idle
        for (i = 0; i < 6; i++) begin
            wr(A_CTRL, rc[i]);
            wr(A_HDR, rh[i]);
            wr(A_GO, 32'h0);
            rd(A_CMD);
            `CHK(q, resp(ra[i], SK_ILLEG, SC_CHECK))
            rd(A_STAT);
            `CHK(q[1:0], 2'h0)
        end
        rd(A_UA);
        `CHK(q, 32'h0)
        // type 1, long header, queued with tagged queuing on, issuer 2
        wr(A_CTRL, 32'h22C);
        wr(A_HDR, 32'hB000);
        wr(A_HDR2, 32'h10);
        wr(A_LBA, 32'h12345678);
        wr(A_BLKLEN, 32'h1000);
        wr(A_GO, 32'h0);
        rd(A_CMD);
        `CHK(q[15], 1'b0)
        rd(A_UA);
        `CHK(q, 32'hFB)
        rd(A_STAT);
        `CHK(q[17:14], 4'h8)
        rd(A_DLEN);
        `CHK(q, 32'h10)
        wr(A_GO, 32'h0);
        rd(A_CMD);
        `CHK(q[7:0], SC_QFULL)
        cmd(CK_OTHER);
        `CHK(q[7:0], SC_QFULL)
        i_far.begin_fmt(3);
        `CHK(fmt_active, 1'b1)
        cmd(CK_OTHER);
        `CHK(q[7:0], SC_CHECK)
        cmd(CK_INQ);
        `CHK(q[7:0], SC_GOOD)
        wr(A_GO, 32'h0);
        rd(A_CMD);
        `CHK(q, resp(AQ_FMT_PROG, SK_NREDY, SC_CHECK))
        cmd(CK_RSENSE);
        `CHK(q, resp(AQ_FMT_PROG, SK_NREDY, SC_GOOD))
        rd(A_REFTAG);
        `CHK(q, 32'h1234567B)
        oc = '0;
        oc.done_ok = 1'b1;
        i_far.end_fmt(oc);
        rd(A_CMD);
        `CHK(q, resp(AQ_NONE, SK_NONE, SC_GOOD))
        rd(A_STAT);
        `CHK(q[5:0], 6'h24)
        rd(A_FMTLEN);
        `CHK(q, 32'h1008)
        // type 2, short header, immediate, tagged queuing off
        wr(A_UA, 32'hFF);
        wr(A_CTRL, 32'h35);
        wr(A_HDR, 32'h1800B200);
        wr(A_EXPTAG, 32'hCAFE0000);
        wr(A_GO, 32'h0);
        rd(A_CMD);
        `CHK({q[15], q[7:0]}, {1'b1, SC_GOOD})
        rd(A_UA);
        `CHK(q, 32'hFE)
        rd(A_STAT);
        `CHK(q[17:14], 4'h4)
        rd(A_DLEN);
        `CHK(q, 32'h18)
        cmd(CK_OTHER);
        `CHK(q[7:0], SC_BUSY)
        i_far.begin_fmt(2);
        rd(A_REFTAG);
        `CHK(q, 32'hCAFE0002)
        oc = '0;
        oc.abort = 1'b1;
        i_far.end_fmt(oc);
        rd(A_STAT);
        `CHK({rw_blocked, q[4], q[1:0]}, 4'hC)
        cmd(CK_RSENSE);
        `CHK({q[31:16], q[11:8]}, {AQ_FMT_BAD, SK_MEDIUM})
        cmd(CK_OTHER);
        `CHK({q[11:8], q[7:0]}, {SK_MEDIUM, SC_CHECK})
        // non-immediate failure on a missing host list
        wr(A_CTRL, 32'h0C);
        wr(A_HDR, 32'hB000);
        wr(A_GO, 32'h0);
        i_far.begin_fmt(0);
        oc = '0;
        oc.dlist_missing = 1'b1;
        i_far.end_fmt(oc);
        rd(A_CMD);
        `CHK(q, resp(AQ_DL_MISS, SK_MEDIUM, SC_CHECK))
        // factory list missing with it in use, then a list read error
        for (i = 0; i < 2; i++) begin
            wr(A_GO, 32'h0);
            i_far.begin_fmt(0);
            oc = '0;
            oc.plist_missing = (i == 0);
            oc.dlist_err = (i == 1);
            i_far.end_fmt(oc);
            rd(A_CMD);
            `CHK(q[31:16], i ? AQ_DL_ERR : AQ_DL_MISS)
        end
        // bare format clears degraded mode, certify from mode bit
        wr(A_CTRL, 32'h02);
        wr(A_GO, 32'h0);
        i_far.begin_fmt(1);
        oc = '0;
        oc.done_ok = 1'b1;
        i_far.end_fmt(oc);
        rd(A_STAT);
        `CHK({rw_blocked, q[12], q[5:4]}, 4'h4)
        rd(A_FMTLEN);
        `CHK(q, 32'h1000)
        close_out();
    end
endmodule
